// [gpio_pkg.sv]
// Package with constants and types for the GPIO ports block
package gpio_pkg;

	// ********************************
	// Register addresses
	// ********************************
	localparam logic [7:0] ADDR_PORT0_LATCH   = 8'h80;
	localparam logic [7:0] ADDR_PORT1_LATCH   = 8'h90;
	localparam logic [7:0] ADDR_CARRIER_SEL   = 8'h9f;
	localparam logic [7:0] ADDR_PORT2_LATCH   = 8'ha0;
	localparam logic [7:0] ADDR_CFG           = 8'haf;
	localparam logic [7:0] ADDR_PORT0_PU_DIS  = 8'hb2;
	localparam logic [7:0] ADDR_PORT1_PU_DIS  = 8'hb3;
	localparam logic [7:0] ADDR_PORT2_PU_DIS  = 8'hb4;

	// ********************************
	// Fields and reset values
	// ********************************
	localparam int         CFG_CARRIER_EN_BIT = 4;
	localparam logic [7:0] PORT2_PU_DIS_MASK  = 8'h27;
	localparam int         RST_PIN_PU_BIT     = 5;
	localparam logic [7:0] LATCH_RESET        = 8'hff;
	localparam logic [7:0] CARRIER_SEL_RESET  = 8'h00;
	localparam logic [7:0] PU_DIS_RESET       = 8'h00;
	localparam logic [7:0] UNMAPPED_READ      = 8'h00;

	// ********************************
	// Carrier timing
	// ********************************
	localparam int CLOCK_HZ     = 20_000_000;
	localparam int CARRIER_HZ   = 38_000;
	localparam int CARRIER_HALF = CLOCK_HZ / (2 * CARRIER_HZ);
	localparam int CARRIER_CW   = $clog2(CARRIER_HALF);

	// ********************************
	// Types
	// ********************************
	typedef logic [2:0][7:0] port_bits_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd_latch;
		logic       rd_pin;
	} sfr_req_t;

endpackage

// [gpio_ports_ir_carrier.sv]
// Three 8-bit GPIO ports with pull-up control and 38 kHz carrier
// What this block does
// - A pin owned by an enabled peripheral is driven by that peripheral only.
// - Each pin of ports 0 and 1 and pins 2..0 of port 2 has a switchable weak pull-up, all enabled after reset.
// - With pull-up off the pin is open drain, never driven high.
// - A port write strobe loads the bus value into that port latch.
// - A read-latch request returns the stored latch value.
// - A read-pin request returns the synchronised external pin level.
// - Latch 0 drives the pin low; latch 1 leaves it to the pull-up.
// - A modulated pin drives latch XOR a 38 kHz square wave.
// - Bit 4 of the register at 0xAF enables the carrier globally.
// - Carrier pin-select register at 0x9F, one bit per pin, reset to zero.
// - Select bits 7..4 map to port 1 pins 6, 5, 4 and 1.
// - Select bits 3..0 map to port 0 pins 2, 7, 5 and 3.
// - Register 0xB2 bit n disables the port 0 pin n pull-up; reset zero.
// - Register 0xB3 bit n disables the port 1 pin n pull-up; reset zero.
// - Register 0xB4 bits 2..0 port 2, bit 5 reset pin; rest kept zero.
// - Latches reset to 1 and stay set while a peripheral owns the pin.
`timescale 1ns/100ps

module gpio_ports_ir_carrier
(
	// Clock and reset
	input  wire logic                 clock_i,
	input  wire logic                 rst_i,
	// Special function register access
	input  wire gpio_pkg::sfr_req_t   sfr_req_i,
	output logic [7:0]                sfr_rdata_o,
	output logic                      sfr_rvalid_o,
	// Peripheral ownership of pins
	input  wire gpio_pkg::port_bits_t periph_own_i,
	input  wire gpio_pkg::port_bits_t periph_lvl_i,
	// Port pins
	input  wire gpio_pkg::port_bits_t pin_i,
	output gpio_pkg::port_bits_t      pin_o,
	output gpio_pkg::port_bits_t      pin_oe_o,
	output gpio_pkg::port_bits_t      pullup_en_o,
	output logic                      rst_pin_pullup_en_o,
	output gpio_pkg::port_bits_t      pin_sync_o
);

	// ********************************
	// Declarations
	// ********************************
	gpio_pkg::port_bits_t latch_r;
	gpio_pkg::port_bits_t pu_dis_r;
	gpio_pkg::port_bits_t sync1_r;
	gpio_pkg::port_bits_t sync2_r;
	gpio_pkg::port_bits_t carrier_mask;
	gpio_pkg::port_bits_t lvl_nxt;
	gpio_pkg::port_bits_t oe_r;
	logic [7:0]           sel_r;
	logic                 carrier_en_r;
	logic                 carrier_r;
	logic [gpio_pkg::CARRIER_CW-1:0] cnt_r;
	logic [7:0]           rdata_r;
	logic                 rvalid_r;
	logic [7:0]           rdata_nxt;

	// ********************************
	// Functions
	// ********************************
	function automatic logic [1:0] port_index(input logic [7:0] a);
		port_index = 2'd3;
		if (a == gpio_pkg::ADDR_PORT0_LATCH)
		begin
			port_index = 2'd0;
		end
		else if (a == gpio_pkg::ADDR_PORT1_LATCH)
		begin
			port_index = 2'd1;
		end
		else if (a == gpio_pkg::ADDR_PORT2_LATCH)
		begin
			port_index = 2'd2;
		end
	endfunction

	function automatic gpio_pkg::port_bits_t sel_to_mask(input logic [7:0] s);
		sel_to_mask = '0;
		sel_to_mask[1][6] = s[7];
		sel_to_mask[1][5] = s[6];
		sel_to_mask[1][4] = s[5];
		sel_to_mask[1][1] = s[4];
		sel_to_mask[0][2] = s[3];
		sel_to_mask[0][7] = s[2];
		sel_to_mask[0][5] = s[1];
		sel_to_mask[0][3] = s[0];
	endfunction

	// ********************************
	// Pin synchroniser
	// ********************************
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			sync1_r <= '1;
			sync2_r <= '1;
		end
		else
		begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
		end
	end

	// ********************************
	// Port latches
	// ********************************
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			latch_r <= {3{gpio_pkg::LATCH_RESET}};
		end
		else
		begin
			for (int p = 0; p < 3; p++)
			begin
				for (int b = 0; b < 8; b++)
				begin
					if (periph_own_i[p][b])
					begin
						latch_r[p][b] <= 1'b1;
					end
					else if (sfr_req_i.wr && port_index(sfr_req_i.addr) == 2'(p))
					begin
						latch_r[p][b] <= sfr_req_i.wdata[b];
					end
				end
			end
		end
	end

	// ********************************
	// Pull-up disable registers
	// ********************************
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			pu_dis_r <= {3{gpio_pkg::PU_DIS_RESET}};
		end
		else if (sfr_req_i.wr)
		begin
			if (sfr_req_i.addr == gpio_pkg::ADDR_PORT0_PU_DIS)
			begin
				pu_dis_r[0] <= sfr_req_i.wdata;
			end
			if (sfr_req_i.addr == gpio_pkg::ADDR_PORT1_PU_DIS)
			begin
				pu_dis_r[1] <= sfr_req_i.wdata;
			end
			if (sfr_req_i.addr == gpio_pkg::ADDR_PORT2_PU_DIS)
			begin
				pu_dis_r[2] <= sfr_req_i.wdata & gpio_pkg::PORT2_PU_DIS_MASK;
			end
		end
	end

	// ********************************
	// Carrier configuration
	// ********************************
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			sel_r        <= gpio_pkg::CARRIER_SEL_RESET;
			carrier_en_r <= 1'b0;
		end
		else if (sfr_req_i.wr)
		begin
			if (sfr_req_i.addr == gpio_pkg::ADDR_CARRIER_SEL)
			begin
				sel_r <= sfr_req_i.wdata;
			end
			if (sfr_req_i.addr == gpio_pkg::ADDR_CFG)
			begin
				carrier_en_r <= sfr_req_i.wdata[gpio_pkg::CFG_CARRIER_EN_BIT];
			end
		end
	end

	// ********************************
	// 38 kHz square wave
	// ********************************
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			cnt_r     <= '0;
			carrier_r <= 1'b0;
		end
		else if (cnt_r == gpio_pkg::CARRIER_CW'(gpio_pkg::CARRIER_HALF - 1))
		begin
			cnt_r     <= '0;
			carrier_r <= ~carrier_r;
		end
		else
		begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// ********************************
	// Pin drive
	// ********************************
	always_comb
	begin
		carrier_mask = carrier_en_r ? sel_to_mask(sel_r) : '0;
		for (int p = 0; p < 3; p++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				lvl_nxt[p][b] = periph_own_i[p][b] ? periph_lvl_i[p][b]
					: latch_r[p][b] ^ (carrier_r & carrier_mask[p][b]);
			end
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			oe_r <= '0;
		end
		else
		begin
			oe_r <= ~lvl_nxt;
		end
	end

	assign pin_o               = '0;
	assign pin_oe_o            = oe_r;
	assign pullup_en_o         = ~{pu_dis_r[2] & ~(8'h01 << gpio_pkg::RST_PIN_PU_BIT), pu_dis_r[1], pu_dis_r[0]};
	assign rst_pin_pullup_en_o = ~pu_dis_r[2][gpio_pkg::RST_PIN_PU_BIT];
	assign pin_sync_o          = sync2_r;

	// ********************************
	// Register readback
	// ********************************
	always_comb
	begin
		rdata_nxt = gpio_pkg::UNMAPPED_READ;
		unique case (sfr_req_i.addr)
			gpio_pkg::ADDR_PORT0_LATCH,
			gpio_pkg::ADDR_PORT1_LATCH,
			gpio_pkg::ADDR_PORT2_LATCH:
			begin
				if (sfr_req_i.rd_pin)
				begin
					rdata_nxt = sync2_r[port_index(sfr_req_i.addr)];
				end
				else
				begin
					rdata_nxt = latch_r[port_index(sfr_req_i.addr)];
				end
			end
			gpio_pkg::ADDR_CARRIER_SEL:  rdata_nxt = sel_r;
			gpio_pkg::ADDR_CFG:
				rdata_nxt[gpio_pkg::CFG_CARRIER_EN_BIT] = carrier_en_r;
			gpio_pkg::ADDR_PORT0_PU_DIS: rdata_nxt = pu_dis_r[0];
			gpio_pkg::ADDR_PORT1_PU_DIS: rdata_nxt = pu_dis_r[1];
			gpio_pkg::ADDR_PORT2_PU_DIS: rdata_nxt = pu_dis_r[2];
			default:                     rdata_nxt = gpio_pkg::UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			rdata_r  <= '0;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rvalid_r <= sfr_req_i.rd_latch | sfr_req_i.rd_pin;
			if (sfr_req_i.rd_latch | sfr_req_i.rd_pin)
			begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	assign sfr_rdata_o  = rdata_r;
	assign sfr_rvalid_o = rvalid_r;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_pullup_after_reset: assert property ($fell(rst_i) |-> pullup_en_o == '1 ##1 rst_pin_pullup_en_o)
		else $error("pull-ups not enabled after reset");
	a_no_drive_high: assert property (pin_o == '0)
		else $error("pin driven high");
	a_latch_write: assert property (sfr_req_i.wr && sfr_req_i.addr == gpio_pkg::ADDR_PORT0_LATCH
		&& periph_own_i[0] == '0 |=> latch_r[0] == $past(sfr_req_i.wdata))
		else $error("port 0 latch not loaded");
	a_read_latch: assert property (sfr_req_i.rd_latch && !sfr_req_i.rd_pin
		&& sfr_req_i.addr == gpio_pkg::ADDR_PORT1_LATCH
		|=> sfr_rvalid_o && sfr_rdata_o == $past(latch_r[1]))
		else $error("latch readback wrong");
	a_read_pin: assert property (sfr_req_i.rd_pin && sfr_req_i.addr == gpio_pkg::ADDR_PORT0_LATCH
		|=> sfr_rdata_o == $past(pin_i[0], 3))
		else $error("pin readback wrong");
	a_drive_low: assert property (!periph_own_i[2][0] && !latch_r[2][0] |=> pin_oe_o[2][0])
		else $error("latch zero not driven low");
	a_carrier_period: assert property ($changed(carrier_r) |=> $stable(carrier_r)[*8])
		else $error("carrier toggled too soon");
	a_carrier_spacing: assert property ($changed(carrier_r) |-> cnt_r == '0)
		else $error("carrier toggled off schedule");
	a_carrier_off: assert property (!carrier_en_r && !periph_own_i[1][1]
		|=> pin_oe_o[1][1] == !$past(latch_r[1][1]))
		else $error("pin modulated while carrier disabled");
	a_sel_reset: assert property ($fell(rst_i) |-> sel_r == '0 && !carrier_en_r)
		else $error("carrier select not cleared by reset");
	a_owned_latch: assert property (periph_own_i[1][2] |=> latch_r[1][2])
		else $error("owned pin latch not set");
	a_owned_drive: assert property (periph_own_i[1][0]
		|=> pin_oe_o[1][0] == !$past(periph_lvl_i[1][0]))
		else $error("owned pin not given to peripheral");
	a_p2_reserved: assert property ((pu_dis_r[2] & ~gpio_pkg::PORT2_PU_DIS_MASK) == '0)
		else $error("reserved pull-up bits set");

	c_carrier_on: cover property (carrier_en_r && sel_r[4] && pin_oe_o[1][1] ##1 !pin_oe_o[1][1]);
	c_read_pin: cover property (sfr_req_i.rd_pin ##1 sfr_rvalid_o);
	c_open_drain: cover property (pu_dis_r[0][0] && pin_oe_o[0][0]);

endmodule

// [gpio_pin_partner.sv]
// External devices and wiring on the port pins
`timescale 1ns/100ps

module gpio_pin_partner
(
	// Clock
	input  wire logic                 clock_i,
	// Pin control from the block
	input  wire gpio_pkg::port_bits_t drv_i,
	input  wire gpio_pkg::port_bits_t oe_i,
	input  wire gpio_pkg::port_bits_t pu_i,
	// Outside drive
	input  wire gpio_pkg::port_bits_t ext_en_i,
	input  wire gpio_pkg::port_bits_t ext_lvl_i,
	// Resolved wire levels
	output gpio_pkg::port_bits_t      pin_o
);
	// ********************************
	// Wire resolution
	// ********************************
	logic float_r = 1'b0;

	always_ff @(posedge clock_i)
		float_r <= ~float_r;

	// Block drive, then outside drive, then pull-up, else a floating pattern
	always_comb
		for (int i = 0; i < 24; i++)
			pin_o[i/8][i%8] = oe_i[i/8][i%8] ? drv_i[i/8][i%8] :
				ext_en_i[i/8][i%8] ? ext_lvl_i[i/8][i%8] :
				pu_i[i/8][i%8] ? 1'b1 : float_r;
endmodule

// [gpio_ports_ir_carrier_tb_top.sv]
// Self-checking testbench for the GPIO ports block
`timescale 1ns/100ps

module gpio_ports_ir_carrier_tb_top;
	// ********************************
	// Signals and tables
	// ********************************
	logic                 clock_i = 1'b0;
	logic                 rst_i   = 1'b1;
	gpio_pkg::sfr_req_t   req     = '0;
	gpio_pkg::port_bits_t own     = '0;
	gpio_pkg::port_bits_t lvl     = '0;
	gpio_pkg::port_bits_t ext_en  = '0;
	gpio_pkg::port_bits_t ext_lvl = '0;
	gpio_pkg::port_bits_t pins;
	gpio_pkg::port_bits_t drv;
	gpio_pkg::port_bits_t oe;
	gpio_pkg::port_bits_t pu;
	gpio_pkg::port_bits_t sync;
	logic [7:0]           rdata;
	logic                 rvalid;
	logic                 rst_pu;
	logic [7:0]           d;
	int                   mismatches  = 0;
	int                   checks_done = 0;
	int                   tg;
	int                   ot;
	localparam int H = gpio_pkg::CARRIER_HALF;
	localparam logic [7:0] RA [8] = '{8'h80, 8'h90, 8'ha0, 8'h9f, 8'hb2, 8'hb3, 8'hb4, 8'haf};
	localparam logic [7:0] RV [8] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] WV [5] = '{8'hff, 8'hff, 8'hff, 8'h27, 8'h10};
	// Carrier target port and pin for each select bit
	localparam int TP [8] = '{0, 0, 0, 0, 1, 1, 1, 1};
	localparam int TB [8] = '{3, 5, 7, 2, 1, 4, 5, 6};

	initial
		forever #25 clock_i = ~clock_i;

	gpio_ports_ir_carrier dut_u
	(
		.clock_i             (clock_i),
		.rst_i               (rst_i),
		.sfr_req_i           (req),
		.sfr_rdata_o         (rdata),
		.sfr_rvalid_o        (rvalid),
		.periph_own_i        (own),
		.periph_lvl_i        (lvl),
		.pin_i               (pins),
		.pin_o               (drv),
		.pin_oe_o            (oe),
		.pullup_en_o         (pu),
		.rst_pin_pullup_en_o (rst_pu),
		.pin_sync_o          (sync)
	);

	gpio_pin_partner far_u
	(
		.clock_i   (clock_i),
		.drv_i     (drv),
		.oe_i      (oe),
		.pu_i      (pu),
		.ext_en_i  (ext_en),
		.ext_lvl_i (ext_lvl),
		.pin_o     (pins)
	);

	// ********************************
	// Tasks
	// ********************************
	task automatic tally_and_finish();
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic chk_n(input string n, input int e, input int g);
		checks_done++;
		if (g != e)
		begin
			mismatches++;
			$display("BAD %s exp %0d got %0d", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clock_i);
		req.addr = a;
		req.wdata = v;
		req.wr = 1'b1;
		@(negedge clock_i);
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic p, output logic [7:0] v);
		@(negedge clock_i);
		req.addr = a;
		req.rd_pin = p;
		req.rd_latch = ~p;
		@(negedge clock_i);
		req.rd_pin = 1'b0;
		req.rd_latch = 1'b0;
		for (int i = 0; i < 4 && rvalid !== 1'b1; i++)
			@(negedge clock_i);
		if (rvalid !== 1'b1)
		begin
			mismatches++;
			tally_and_finish();
		end
		else
			v = rdata;
	endtask

	// Counts toggles of one pin enable and changes on all other pins
	task automatic cnt(input int p, input int b, input int n);
		gpio_pkg::port_bits_t prev;
		tg = 0;
		ot = 0;
		repeat (2) @(negedge clock_i);
		prev = oe;
		repeat (n)
		begin
			@(negedge clock_i);
			if (oe[p][b] !== prev[p][b])
				tg++;
			prev[p][b] = oe[p][b];
			if (oe !== prev)
				ot++;
			prev = oe;
		end
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial
	begin
		repeat (20) @(negedge clock_i);
		rst_i = 1'b0;
		for (int p = 0; p < 3; p++)
		begin
			chk("pullup_en", 8'hff, pu[p]);
			chk("pin_oe", 8'h00, oe[p]);
		end
		chk("rst_pullup", 8'h01, {7'h00, rst_pu});
		for (int i = 0; i < 8; i++)
		begin
			rd(RA[i], 1'b0, d);
			chk("reset_value", RV[i], d);
		end
		wr(8'h55, 8'h12);
		rd(8'h55, 1'b0, d);
		chk("unmapped", 8'h00, d);
		for (int i = 0; i < 5; i++)
		begin
			wr(RA[i+3], 8'hff);
			rd(RA[i+3], 1'b0, d);
			chk("readback", WV[i], d);
		end
		chk("pullup_en0", 8'h00, pu[0]);
		chk("pullup_en1", 8'h00, pu[1]);
		chk("pullup_en2", 8'hf8, pu[2]);
		chk("rst_pullup", 8'h00, {7'h00, rst_pu});
		for (int i = 3; i < 8; i++)
			wr(RA[i], 8'h00);
		// Latch drive and the two readback paths
		wr(8'h80, 8'h5a);
		repeat (4) @(negedge clock_i);
		chk("pin_oe0", 8'ha5, oe[0]);
		chk("pin_drv0", 8'h00, drv[0]);
		wr(8'ha0, 8'h00);
		repeat (3) @(negedge clock_i);
		chk("pin_oe2", 8'hff, oe[2]);
		wr(8'ha0, 8'hff);
		repeat (3) @(negedge clock_i);
		chk("pin_oe2_off", 8'h00, oe[2]);
		rd(8'h80, 1'b1, d);
		chk("pin_read", 8'h5a, d);
		ext_en[0] = 8'h02;
		repeat (4) @(negedge clock_i);
		rd(8'h80, 1'b1, d);
		chk("pin_read", 8'h58, d);
		chk("pin_sync", 8'h58, sync[0]);
		rd(8'h80, 1'b0, d);
		chk("latch_read", 8'h5a, d);
		wr(8'hb2, 8'h02);
		ext_lvl[0] = 8'h02;
		repeat (4) @(negedge clock_i);
		rd(8'h80, 1'b1, d);
		chk("od_read", 8'h5a, d);
		// Peripheral ownership
		own[1] = 8'h0f;
		lvl[1] = 8'h05;
		wr(8'h90, 8'h00);
		repeat (4) @(negedge clock_i);
		rd(8'h90, 1'b0, d);
		chk("owned_latch", 8'h0f, d);
		chk("owned_oe", 8'hfa, oe[1]);
		own[1] = 8'h00;
		wr(8'h90, 8'hff);
		wr(8'h80, 8'hff);
		// Carrier period, pin map and global enable
		wr(8'h9f, 8'h10);
		wr(8'haf, 8'h10);
		cnt(1, 1, 4 * H);
		chk_n("carrier_toggles", 4, tg);
		chk_n("other_toggles", 0, ot);
		for (int k = 0; k < 8; k++)
		begin
			wr(8'h9f, 8'h01 << k);
			cnt(TP[k], TB[k], 2 * H);
			chk_n("map_toggles", 2, tg);
			chk_n("map_other", 0, ot);
		end
		wr(8'haf, 8'h00);
		cnt(1, 6, 2 * H);
		chk_n("disabled_toggles", 0, tg);
		chk("disabled_oe", 8'h00, oe[1]);
		tally_and_finish();
	end
endmodule
